/* adc_result_formatting_test.sv */
// Self-checking bench of the converter result formatter.
`timescale 1ns/1ps
`include "adcrf_consts.svh"

module adc_result_formatting_test import adcrf_pkg::*;;
    // The acquisition wait covers settling, charging and a temperature margin at this clock.
    localparam int ACQ_CYCLES = 47;
    logic                     ref_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic [`ADCRF_ADDR_W-1:0] addr = '0;
    logic [7:0]               wdata = 8'h00;
    logic                     wr_stb = 1'b0;
    logic                     rd_stb = 1'b0;
    logic [7:0]               rdata;
    logic [`ADCRF_RES_W-1:0]  conversion_result_value = '0;
    logic                     sample_hold;
    logic                     conv_busy;
    int                       fail_count = 0;
    int                       checks = 0;
    int                       seed = 32'hcb505913;
    logic [7:0]               got, hi_keep, lo_keep;

    adcrf_top adcrf_top_i (
        .ref_clk                 (ref_clk),
        .resetn                  (resetn),
        .addr                    (addr),
        .wdata                   (wdata),
        .wr_stb                  (wr_stb),
        .rd_stb                  (rd_stb),
        .rdata                   (rdata),
        .conversion_result_value (conversion_result_value),
        .sample_hold             (sample_hold),
        .conv_busy               (conv_busy)
    );

    always #50 ref_clk = ~ref_clk;

    task automatic complete_run();
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Every task is entered just after a rising edge and leaves a gap cycle behind its strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge ref_clk); wr_stb <= 1'b0;
        @(posedge ref_clk); #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a; rd_stb <= 1'b1;
        @(posedge ref_clk); rd_stb <= 1'b0;
        #1 d = rdata;
        @(posedge ref_clk); #1;
    endtask

    function automatic logic [7:0] exp_reg(logic [9:0] v, logic right, logic high);
        if (right) return high ? {6'h00, v[9:8]} : v[7:0];
        return high ? v[9:2] : {v[1:0], 6'h00};
    endfunction

    task automatic convert(input logic [9:0] v, input logic right);
        int n;
        conversion_result_value <= v;
        repeat (ACQ_CYCLES) @(posedge ref_clk);
        #1 wr(`ADCRF_OFF_CTRL, {right, 7'h02});
        chk("busy", {7'h00, conv_busy}, 8'h01);
        chk("hold", {7'h00, sample_hold}, 8'h01);
        rd(`ADCRF_OFF_STATUS, got);
        chk("status", {6'h00, got[1:0]}, 8'h03);
        rd(`ADCRF_OFF_CTRL, got);
        chk("ctrl", got, {right, 5'h00, 1'b1, 1'b0});
        n = 6;
        for (int k = 0; k < 200 && conv_busy === 1'b1; k++) begin
            @(posedge ref_clk); #1;
            if (conv_busy === 1'b1) n++;
        end
        if (conv_busy !== 1'b0) begin
            fail_count++;
            complete_run();
        end else begin
            chk("length", n[7:0], 8'(`ADCRF_CONV_CYCLES + 1));
            chk("released", {7'h00, sample_hold}, 8'h00);
            rd(`ADCRF_OFF_RES_HIGH, got);
            chk("high", got, exp_reg(v, right, 1'b1));
            rd(`ADCRF_OFF_RES_LOW, got);
            chk("low", got, exp_reg(v, right, 1'b0));
        end
    endtask

    initial begin
        logic [9:0] v;
        logic [7:0] d;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk); #1;
        chk("busy_rst", {7'h00, conv_busy}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            wr(`ADCRF_OFF_RES_HIGH, d);
            wr(`ADCRF_OFF_RES_LOW, ~d);
            rd(`ADCRF_OFF_RES_HIGH, got);
            chk("high_rw", got, d);
            rd(`ADCRF_OFF_RES_LOW, got);
            chk("low_rw", got, ~d);
            rd(4'(4 + ($random(seed) & 32'hb)), got);
            chk("unmapped", got, 8'h00);
        end
        // Extremes and an alternating pattern come first, so both formats meet every edge bit.
        for (int i = 0; i < 12; i++) begin
            v = (i < 2) ? 10'h3ff : (i < 4) ? 10'h000 : (i < 6) ? 10'h2aa : 10'($random(seed));
            convert(v, i[0]);
        end
        // The last conversion ran right justified, so the kept values follow from it.
        hi_keep = exp_reg(v, 1'b1, 1'b1);
        lo_keep = exp_reg(v, 1'b1, 1'b0);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk); #1;
        rd(`ADCRF_OFF_RES_HIGH, got);
        chk("high_kept", got, hi_keep);
        rd(`ADCRF_OFF_RES_LOW, got);
        chk("low_kept", got, lo_keep);
        convert(10'h155, 1'b0);
        complete_run();
    end
endmodule // adc_result_formatting_test

/* adcrf_consts.svh */
// Register offsets, field positions, widths and timing counts of the result formatter.
`ifndef ADCRF_CONSTS_SVH
`define ADCRF_CONSTS_SVH
`define ADCRF_ADDR_W        4
`define ADCRF_OFF_CTRL      4'h0
`define ADCRF_OFF_RES_HIGH  4'h1
`define ADCRF_OFF_RES_LOW   4'h2
`define ADCRF_OFF_STATUS    4'h3
`define ADCRF_CTRL_GO_BIT   1
`define ADCRF_CTRL_FMT_BIT  7
`define ADCRF_RES_W         10
`define ADCRF_CLK_HZ        10000000
`define ADCRF_CONV_TIME_NS  2000
`define ADCRF_CONV_CYCLES   (((`ADCRF_CONV_TIME_NS) * ((`ADCRF_CLK_HZ) / 1000000) + 999) / 1000)
`define ADCRF_CNT_W         8
`define ADCRF_SAMPLE_CYCLE  8'h01
`endif

/* adcrf_pkg.sv */
// Types shared by the result formatter.
package adcrf_pkg;
    typedef enum logic [1:0] {ADCRF_IDLE, ADCRF_CONVERT, ADCRF_LOAD} adcrf_state_t;
endpackage

/* adcrf_top.sv */
// Result formatting and conversion sequencing of a ten-bit converter.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "adcrf_consts.svh"

module adcrf_top
    import adcrf_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire logic [`ADCRF_ADDR_W-1:0]  addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [7:0]                rdata,
    input  wire logic [`ADCRF_RES_W-1:0]   conversion_result_value,
    output logic                           sample_hold,
    output logic                           conv_busy
);
    adcrf_state_t               state;
    adcrf_state_t               next_state;
    logic [`ADCRF_CNT_W-1:0]    cnt;
    logic [`ADCRF_CNT_W-1:0]    next_cnt;
    logic                       result_justify_select;
    logic                       next_result_justify_select;
    logic                       go;
    logic                       next_go;
    logic [7:0]                 conversion_result_high;
    logic [7:0]                 next_conversion_result_high;
    logic [7:0]                 conversion_result_low;
    logic [7:0]                 next_conversion_result_low;
    logic [7:0]                 next_rdata;
    logic                       next_sample_hold;

    wire wr_ctrl = wr_stb && (addr == `ADCRF_OFF_CTRL);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_go = go;
        next_result_justify_select = result_justify_select;
        next_sample_hold = sample_hold;
        if (wr_ctrl) begin
            next_result_justify_select = wdata[`ADCRF_CTRL_FMT_BIT];
        end
        unique case (state)
            ADCRF_IDLE: begin
                // A write of one starts; software owns the acquisition wait before it.
                if (wr_ctrl && wdata[`ADCRF_CTRL_GO_BIT]) begin
                    next_go = 1'b1;
                    next_state = ADCRF_CONVERT;
                    next_cnt = `ADCRF_CNT_W'(`ADCRF_CONV_CYCLES);
                    next_sample_hold = 1'b1;
                end
            end
            ADCRF_CONVERT: begin
                if (cnt == `ADCRF_SAMPLE_CYCLE) begin
                    next_state = ADCRF_LOAD;
                end
                next_cnt = cnt - `ADCRF_SAMPLE_CYCLE;
            end
            ADCRF_LOAD: begin
                // Hold is released, not discharged, so its charge carries over.
                next_sample_hold = 1'b0;
                next_go = 1'b0;
                next_state = ADCRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ADCRF_IDLE;
            cnt <= '0;
            go <= 1'b0;
            result_justify_select <= 1'b0;
            sample_hold <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            go <= next_go;
            result_justify_select <= next_result_justify_select;
            sample_hold <= next_sample_hold;
        end
    end

    // Result registers carry no reset, so their content survives a reset unchanged.
    always_comb begin
        next_conversion_result_high = conversion_result_high;
        next_conversion_result_low = conversion_result_low;
        if (state == ADCRF_LOAD) begin
            if (result_justify_select) begin
                next_conversion_result_high = {6'h00, conversion_result_value[9:8]};
                next_conversion_result_low = conversion_result_value[7:0];
            end else begin
                next_conversion_result_high = conversion_result_value[9:2];
                next_conversion_result_low = {conversion_result_value[1:0], 6'h00};
            end
        end else if (wr_stb && addr == `ADCRF_OFF_RES_HIGH) begin
            next_conversion_result_high = wdata;
        end else if (wr_stb && addr == `ADCRF_OFF_RES_LOW) begin
            next_conversion_result_low = wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        conversion_result_high <= next_conversion_result_high;
        conversion_result_low <= next_conversion_result_low;
    end

    always_comb begin
        next_rdata = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                `ADCRF_OFF_CTRL:     next_rdata = {result_justify_select, 5'h00, go, 1'b0};
                `ADCRF_OFF_RES_HIGH: next_rdata = conversion_result_high;
                `ADCRF_OFF_RES_LOW:  next_rdata = conversion_result_low;
                `ADCRF_OFF_STATUS:   next_rdata = {6'h00, sample_hold, go};
                default:             next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
            conv_busy <= 1'b0;
        end else begin
            rdata <= next_rdata;
            conv_busy <= next_go;
        end
    end

    property p_left_high;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ADCRF_LOAD && !result_justify_select)
            |=> conversion_result_high == $past(conversion_result_value[9:2]);
    endproperty
    a_left_high: assert property (p_left_high) else $error("left high wrong");

    property p_left_low;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ADCRF_LOAD && !result_justify_select)
            |=> conversion_result_low == {$past(conversion_result_value[1:0]), 6'h00};
    endproperty
    a_left_low: assert property (p_left_low) else $error("left low wrong");

    property p_right_high;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ADCRF_LOAD && result_justify_select)
            |=> conversion_result_high == {6'h00, $past(conversion_result_value[9:8])};
    endproperty
    a_right_high: assert property (p_right_high) else $error("right high wrong");

    property p_right_low;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ADCRF_LOAD && result_justify_select)
            |=> conversion_result_low == $past(conversion_result_value[7:0]);
    endproperty
    a_right_low: assert property (p_right_low) else $error("right low wrong");

    property p_sw_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr_stb && addr == `ADCRF_OFF_RES_HIGH && state != ADCRF_LOAD)
            |=> conversion_result_high == $past(wdata);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("result write lost");

    property p_go_sets;
        @(posedge ref_clk) disable iff (!resetn)
        (state == ADCRF_IDLE && wr_ctrl && wdata[`ADCRF_CTRL_GO_BIT])
            |=> go && conv_busy ##21 !go;
    endproperty
    a_go_sets: assert property (p_go_sets) else $error("conversion timing wrong");

    property p_same_cycle;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(go) |-> $past(state == ADCRF_LOAD);
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("clear without load");

    property p_hold_release;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(go) |-> !sample_hold;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold not released");

    property p_sw_write_low;
        @(posedge ref_clk) disable iff (!resetn)
        (wr_stb && addr == `ADCRF_OFF_RES_LOW && state != ADCRF_LOAD)
            |=> conversion_result_low == $past(wdata);
    endproperty
    a_sw_write_low: assert property (p_sw_write_low) else $error("low write lost");

    property p_read_high;
        @(posedge ref_clk) disable iff (!resetn)
        (rd_stb && addr == `ADCRF_OFF_RES_HIGH)
            |=> rdata == $past(conversion_result_high);
    endproperty
    a_read_high: assert property (p_read_high) else $error("high read wrong");

    // Read data stand for one cycle only, so a stale value never passes for a fresh read.
    property p_read_idle;
        @(posedge ref_clk) disable iff (!resetn)
        !rd_stb |=> rdata == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not cleared");

    c_left: cover property (@(posedge ref_clk) state == ADCRF_LOAD && !result_justify_select);
    c_right: cover property (@(posedge ref_clk) state == ADCRF_LOAD && result_justify_select);
    c_read: cover property (@(posedge ref_clk) rd_stb && addr == `ADCRF_OFF_RES_LOW);
    c_sw_write: cover property (@(posedge ref_clk) wr_stb && addr == `ADCRF_OFF_RES_HIGH);
endmodule // adcrf_top
